/* File: rtl/cbr_block_ram.sv */
// Configurable block memory: SP, TDP, PDP and FIFO modes with preload
//
// Contract
// - SP and TDP offer 8192x1, 4096x2, 2048x4 and 1024x9.
// - PDP and FIFO add the 512x18 shape.
// - Each port of a multi-port mode picks its own width.
// - Word n occupies bits n*W up to n*W+W-1, LSB first, per port.
// - Contents may be preloaded during configuration before use.
// - Preload comes from user flash; all-zero image reads no flash.
// - Blocks with identical images share one flash image area.
// - ROM use: preload, then writes are held disabled.
// - Address and write data are registered at the array input.
// - Read data leaves directly or via optional output register.
// - Blocks combine into wider or deeper memories.
`timescale 1ns/100ps
`default_nettype none
module cbr_block_ram
  import cbr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  cfg_mode,
  input  wire logic [2:0]  cfg_width_a,
  input  wire logic [2:0]  cfg_width_b,
  input  wire logic        cfg_out_reg,
  input  wire logic        cfg_wr_lock,
  input  wire logic        cfg_init_start,
  input  wire logic        cfg_init_zero,
  input  wire logic [15:0] cfg_image_base,
  output logic             cfg_busy,
  output logic             flash_rd_req,
  output logic [15:0]      flash_rd_addr,
  input  wire logic        flash_rd_valid,
  input  wire logic [17:0] flash_rd_data,
  input  wire logic        a_cs,
  input  wire logic        a_en,
  input  wire logic        a_we,
  input  wire logic [12:0] a_addr,
  input  wire logic [17:0] a_din,
  output logic [17:0]      a_dout,
  input  wire logic        b_cs,
  input  wire logic        b_en,
  input  wire logic        b_we,
  input  wire logic [12:0] b_addr,
  input  wire logic [17:0] b_din,
  output logic [17:0]      b_dout,
  output logic             fifo_full,
  output logic             fifo_empty
);
  // ---------------------------------------------------------------
  // Shape helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] wbits(input cbr_wsel_t w);
    case (w)
      CBR_W2:  wbits = 5'd2;
      CBR_W4:  wbits = 5'd4;
      CBR_W9:  wbits = 5'd9;
      CBR_W18: wbits = 5'd18;
      default: wbits = 5'd1;
    endcase
  endfunction

  // First bit of a word: word n starts at n times the width
  function automatic logic [13:0] word_base(input logic [12:0] a,
                                            input cbr_wsel_t w);
    case (w)
      CBR_W2:  word_base = {1'b0, a[11:0], 1'b0};
      CBR_W4:  word_base = {1'b0, a[10:0], 2'b00};
      CBR_W9:  word_base = {1'b0, a[9:0], 3'b000} + {4'h0, a[9:0]};
      CBR_W18: word_base = {1'b0, a[8:0], 4'h0} + {4'h0, a[8:0], 1'b0};
      default: word_base = {1'b0, a};
    endcase
  endfunction

  function automatic logic [13:0] wrap(input logic [13:0] i,
                                       input logic [13:0] cap);
    wrap = (i >= cap) ? i - cap : i;
  endfunction

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  cbr_mode_t   mode;
  cbr_wsel_t   eff_a, eff_b;
  logic        two_sided, is_fifo;
  logic [4:0]  wa, wb;
  logic [13:0] cap;
  cbr_state_t  state;

  // 512x18 only exists where one port reads and the other writes
  assign mode      = cbr_mode_t'(cfg_mode);
  assign two_sided = (mode == CBR_PDP) || (mode == CBR_FIFO);
  assign is_fifo   = (mode == CBR_FIFO);
  assign eff_a = (cfg_width_a > 3'h4) ? CBR_W1 :
                 (!two_sided && cfg_width_a == 3'h4) ? CBR_W9 :
                 cbr_wsel_t'(cfg_width_a);
  assign eff_b = (cfg_width_b > 3'h4) ? CBR_W1 :
                 (!two_sided && cfg_width_b == 3'h4) ? CBR_W9 :
                 cbr_wsel_t'(cfg_width_b);
  assign wa  = wbits(eff_a);
  assign wb  = wbits(eff_b);
  // Mixed narrow/wide FIFO widths fall back to the smaller capacity
  assign cap = (is_fifo && (eff_a < CBR_W9 || eff_b < CBR_W9)) ?
               CAP_NARROW : CAP_WIDE;

  // ---------------------------------------------------------------
  // Port request decode
  // ---------------------------------------------------------------
  logic        a_go, b_go, push, pop, a_wr, b_wr, a_rd, b_rd;
  logic [13:0] wptr, rptr, next_a_base, next_b_base;
  logic [13:0] count, next_count;

  // Chip selects let fabric decode several blocks into one memory
  assign a_go = a_en && a_cs && !cfg_busy;
  assign b_go = b_en && b_cs && !cfg_busy && mode != CBR_SP;
  assign push = is_fifo && a_go && a_we && !cfg_wr_lock && !fifo_full;
  assign pop  = is_fifo && b_go && !fifo_empty;
  assign a_wr = is_fifo ? push : a_go && a_we && !cfg_wr_lock;
  assign a_rd = a_go && !a_we && (mode == CBR_SP || mode == CBR_TDP);
  assign b_wr = mode == CBR_TDP && b_go && b_we && !cfg_wr_lock;
  assign b_rd = is_fifo ? pop :
                b_go && (mode == CBR_PDP || !b_we);
  assign next_a_base = is_fifo ? wptr : word_base(a_addr, eff_a);
  assign next_b_base = is_fifo ? rptr : word_base(b_addr, eff_b);
  assign next_count  = count + (push ? {9'h0, wa} : 14'h0)
                             - (pop  ? {9'h0, wb} : 14'h0);

  // ---------------------------------------------------------------
  // Input capture stage
  // ---------------------------------------------------------------
  logic        a_wr_q, a_rd_q, b_wr_q, b_rd_q;
  logic [13:0] a_base_q, b_base_q;
  logic [17:0] a_din_q, b_din_q;

  // Address and data are held a cycle so the array sees stable inputs
  always_ff @(posedge core_clk) begin
    a_base_q <= next_a_base;
    b_base_q <= next_b_base;
    a_din_q  <= a_din;
    b_din_q  <= b_din;
    if (rst) begin
      {a_wr_q, a_rd_q, b_wr_q, b_rd_q} <= 4'h0;
    end else begin
      {a_wr_q, a_rd_q, b_wr_q, b_rd_q} <= {a_wr, a_rd, b_wr, b_rd};
    end
  end

  // ---------------------------------------------------------------
  // FIFO pointers and flags
  // ---------------------------------------------------------------
  // Flags come from the same count that gates push and pop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wptr       <= COUNT_RST;
      rptr       <= COUNT_RST;
      count      <= COUNT_RST;
      fifo_full  <= 1'b0;
      fifo_empty <= 1'b1;
    end else begin
      if (push) wptr <= wrap(wptr + {9'h0, wa}, cap);
      if (pop) rptr <= wrap(rptr + {9'h0, wb}, cap);
      count      <= next_count;
      fifo_full  <= ({1'b0, next_count} + {10'h0, wa}) > {1'b0, cap};
      fifo_empty <= next_count < {9'h0, wb};
    end
  end

  // ---------------------------------------------------------------
  // Configuration preload
  // ---------------------------------------------------------------
  logic [8:0]  init_cnt;
  logic [15:0] image_base;
  logic        init_wr;
  logic [17:0] init_data;

  assign init_wr   = (state == CBR_ZERO) ||
                     (state == CBR_WAIT && flash_rd_valid);
  assign init_data = (state == CBR_ZERO) ? 18'h00000 : flash_rd_data;

  // Zero images clear locally so they never spend user flash reads
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state         <= CBR_IDLE;
      init_cnt      <= 9'h000;
      image_base    <= 16'h0000;
      flash_rd_req  <= 1'b0;
      flash_rd_addr <= 16'h0000;
      cfg_busy      <= 1'b0;
    end else begin
      flash_rd_req <= 1'b0;
      case (state)
        CBR_IDLE: begin
          if (cfg_init_start) begin
            init_cnt   <= 9'h000;
            image_base <= cfg_image_base;
            state      <= cfg_init_zero ? CBR_ZERO : CBR_FETCH;
          end
        end
        CBR_FETCH: begin
          flash_rd_req  <= 1'b1;
          flash_rd_addr <= image_base + {7'h00, init_cnt};
          state         <= CBR_WAIT;
        end
        CBR_WAIT: begin
          if (flash_rd_valid) begin
            init_cnt <= init_cnt + 9'h001;
            state    <= (init_cnt == INIT_LAST) ? CBR_IDLE : CBR_FETCH;
          end
        end
        CBR_ZERO: begin
          init_cnt <= init_cnt + 9'h001;
          if (init_cnt == INIT_LAST) state <= CBR_IDLE;
        end
        default: state <= CBR_IDLE;
      endcase
      cfg_busy <= (state != CBR_IDLE) || cfg_init_start;
    end
  end

  // ---------------------------------------------------------------
  // Storage array
  // ---------------------------------------------------------------
  logic        mem [0:BITS_TOTAL-1];
  logic [17:0] arr_a, arr_b;
  logic [13:0] init_bit;

  assign init_bit = {1'b0, init_cnt, 4'h0} + {4'h0, init_cnt, 1'b0};

  // Port B is written after A at each bit offset, so it wins a same-bit TDP collision unless A's bit offset is the higher one
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DATA_W; i++) begin
      if (init_wr) mem[init_bit + 14'(i)] <= init_data[i];
      if (a_wr_q && 5'(i) < wa)
        mem[wrap(a_base_q + 14'(i), cap)] <= a_din_q[i];
      if (b_wr_q && 5'(i) < wb)
        mem[wrap(b_base_q + 14'(i), cap)] <= b_din_q[i];
    end
  end

  // Unused high bits of a narrow word read as zero
  for (genvar g = 0; g < DATA_W; g++) begin : g_rd
    assign arr_a[g] = (5'(g) < wa) ?
                      mem[wrap(a_base_q + 14'(g), cap)] : 1'b0;
    assign arr_b[g] = (5'(g) < wb) ?
                      mem[wrap(b_base_q + 14'(g), cap)] : 1'b0;
  end

  // ---------------------------------------------------------------
  // Read outputs
  // ---------------------------------------------------------------
  logic [17:0] a_s1, b_s1;

  // Output register costs a cycle but eases fabric timing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      a_s1   <= DOUT_RST;
      b_s1   <= DOUT_RST;
      a_dout <= DOUT_RST;
      b_dout <= DOUT_RST;
    end else begin
      if (a_rd_q) a_s1 <= arr_a;
      if (b_rd_q) b_s1 <= arr_b;
      a_dout <= cfg_out_reg ? a_s1 : (a_rd_q ? arr_a : a_dout);
      b_dout <= cfg_out_reg ? b_s1 : (b_rd_q ? arr_b : b_dout);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_rd_reg;
    (a_rd_q && cfg_out_reg) ##1 cfg_out_reg;
  endsequence

  a_wide_shape: assert property (
    !two_sided |-> eff_a != CBR_W18 && eff_b != CBR_W18)
    else $error("x18 shape outside PDP/FIFO");
  a_pdp_wide: assert property (
    two_sided && cfg_width_b == 3'h4 |-> wb == 5'd18)
    else $error("x18 not offered in PDP/FIFO");
  // Only the low ten address bits select a x9 word
  a_bit_order: assert property (
    a_go && !is_fifo && eff_a == CBR_W9
    |=> a_base_q == 14'($past(a_addr[9:0])) * 14'd9)
    else $error("x9 word not placed at n*9");
  a_zero_noflash: assert property (
    state == CBR_ZERO |-> !flash_rd_req)
    else $error("zero image read user flash");
  a_shared_image: assert property (
    flash_rd_req |-> flash_rd_addr == image_base + {7'h00, init_cnt})
    else $error("flash address not in image area");
  a_rom_lock: assert property (
    cfg_wr_lock && !is_fifo |=> !a_wr_q && !b_wr_q)
    else $error("write while locked");
  // Compares with the pin address, not with the internal base copy
  a_capture: assert property (
    b_go && !is_fifo && eff_b == CBR_W1
    |=> b_base_q == {1'b0, $past(b_addr)})
    else $error("port b address not captured");
  a_out_reg: assert property (
    s_rd_reg |=> a_dout == $past(arr_a, 2))
    else $error("registered read latency wrong");
  a_bypass_lat: assert property (
    a_rd_q && !cfg_out_reg |=> a_dout == $past(arr_a))
    else $error("bypass read latency wrong");
  a_full_drop: assert property (
    is_fifo && fifo_full && a_go && a_we |=> $stable(wptr))
    else $error("write taken while full");
  a_empty_drop: assert property (
    fifo_empty && b_go |=> $stable(rptr))
    else $error("read taken while empty");
  a_zero_end: assert property (
    state == CBR_ZERO && init_cnt == INIT_LAST
    |=> state == CBR_IDLE ##1 !cfg_busy)
    else $error("zero preload did not end");
endmodule // cbr_block_ram
`default_nettype wire

/* File: rtl/cbr_pkg.sv */
// Constants and types for the configurable block memory
package cbr_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int          DATA_W     = 18;
  localparam int          ADDR_W     = 13;
  localparam int          BIT_W      = 14;
  localparam int          BITS_TOTAL = 9216;
  localparam logic [13:0] CAP_WIDE   = 14'h2400; // 9216 bits, x9/x18
  localparam logic [13:0] CAP_NARROW = 14'h2000; // 8192 bits, x1..x4
  localparam int          IMG_W      = 16;
  localparam logic [8:0]  INIT_LAST  = 9'h1ff;   // 512 words of 18 bits
  localparam logic [13:0] COUNT_RST  = 14'h0000;
  localparam logic [17:0] DOUT_RST   = 18'h00000;

  // ---------------------------------------------------------------
  // Modes, shapes and init states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CBR_SP = 2'h0, CBR_TDP = 2'h1, CBR_PDP = 2'h2, CBR_FIFO = 2'h3
  } cbr_mode_t;

  typedef enum logic [2:0] {
    CBR_W1 = 3'h0, CBR_W2 = 3'h1, CBR_W4 = 3'h2, CBR_W9 = 3'h3,
    CBR_W18 = 3'h4
  } cbr_wsel_t;

  typedef enum logic [1:0] {
    CBR_IDLE = 2'h0, CBR_FETCH = 2'h1, CBR_WAIT = 2'h3, CBR_ZERO = 2'h2
  } cbr_state_t;
endpackage

/* File: sim/cbr_flash_model.sv */
// Behavioural user flash that serves preload image words
`timescale 1ns/100ps
`default_nettype none
module cbr_flash_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        flash_rd_req,
  input  wire logic [15:0] flash_rd_addr,
  output var  logic        flash_rd_valid,
  output var  logic [17:0] flash_rd_data
);
  // ---------------------------------------------------------------
  // Read service
  // ---------------------------------------------------------------
  logic [15:0] addr_q;
  logic [1:0]  wait_q;
  logic        pend;
  int          seed = 1;
  // Random wait of 0..3 cycles; data toggles only while no read is pending so stale
  // words can never pass for a real answer
  always @(posedge core_clk) begin
    flash_rd_valid <= 1'b0;
    if (rst) begin
      pend          <= 1'b0;
      flash_rd_data <= 18'h00000;
    end else if (flash_rd_req) begin
      pend   <= 1'b1;
      addr_q <= flash_rd_addr;
      wait_q <= 2'($random(seed));
    end else if (pend && wait_q == 2'h0) begin
      pend           <= 1'b0;
      flash_rd_valid <= 1'b1;
      flash_rd_data  <= {addr_q[1:0], addr_q};
    end else if (pend) begin
      wait_q <= wait_q - 2'h1;
    end else begin
      flash_rd_data <= ~flash_rd_data;
    end
  end
endmodule // cbr_flash_model
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the configurable block memory
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cbr_pkg::*;
  typedef struct {int due; bit p; logic [17:0] v;} cbr_exp_t;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        core_clk = 1'b0, rst = 1'b1;
  logic [1:0]  cfg_mode = 2'h2;
  logic [2:0]  cfg_width_a = 3'h3, cfg_width_b = 3'h4;
  logic        cfg_out_reg = 1'b0, cfg_wr_lock = 1'b0;
  logic        cfg_init_start = 1'b0, cfg_init_zero = 1'b0;
  logic [15:0] cfg_image_base = 16'h1230;
  logic        a_cs = 1'b0, a_en = 1'b0, a_we = 1'b0;
  logic        b_cs = 1'b0, b_en = 1'b0, b_we = 1'b0;
  logic [12:0] a_addr = 13'h0000, b_addr = 13'h0000;
  logic [17:0] a_din = 18'h00000, b_din = 18'h00000;
  logic        cfg_busy, flash_rd_req, flash_rd_valid;
  logic        fifo_full, fifo_empty;
  logic [15:0] flash_rd_addr;
  logic [17:0] flash_rd_data, a_dout, b_dout, r, m;
  logic [17:0] pushed [$];
  cbr_exp_t    q [$];
  cbr_exp_t    e;
  int          cyc = 0, err_count = 0, compares = 0, seed = 1;
  int          top;

  cbr_block_ram cbr_block_ram_inst (.core_clk(core_clk), .rst(rst),
    .cfg_mode(cfg_mode), .cfg_width_a(cfg_width_a),
    .cfg_width_b(cfg_width_b), .cfg_out_reg(cfg_out_reg),
    .cfg_wr_lock(cfg_wr_lock), .cfg_init_start(cfg_init_start),
    .cfg_init_zero(cfg_init_zero), .cfg_image_base(cfg_image_base),
    .cfg_busy(cfg_busy), .flash_rd_req(flash_rd_req),
    .flash_rd_addr(flash_rd_addr), .flash_rd_valid(flash_rd_valid),
    .flash_rd_data(flash_rd_data), .a_cs(a_cs), .a_en(a_en), .a_we(a_we),
    .a_addr(a_addr), .a_din(a_din), .a_dout(a_dout), .b_cs(b_cs),
    .b_en(b_en), .b_we(b_we), .b_addr(b_addr), .b_din(b_din),
    .b_dout(b_dout), .fifo_full(fifo_full), .fifo_empty(fifo_empty));
  cbr_flash_model cbr_flash_model_inst (.core_clk(core_clk), .rst(rst),
    .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
    .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data));

  // ---------------------------------------------------------------
  // Clock, timeout and checking tasks
  // ---------------------------------------------------------------
  always #2 core_clk = ~core_clk;
  // Ceiling well above two preloads plus the FIFO sweep
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic check_data(input logic [17:0] got, input logic [17:0] x);
    compares++;
    if (got !== x) begin
      err_count++;
      $display("CHECK FAILED at %0t: data %h, expected %h", $time, got, x);
    end
  endtask
  task automatic check_flag(input logic got, input logic x);
    compares++;
    if (got !== x) begin
      err_count++;
      $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, x);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One request per cycle on one port; the other port is idled
  task automatic port_op(input bit p, input bit we, input logic [12:0] ad,
                         input logic [17:0] d);
    @(negedge core_clk);
    {a_cs, a_en, a_we, b_cs, b_en, b_we} =
      p ? {3'b000, 2'b11, we} : {2'b11, we, 3'b000};
    if (p) begin
      b_addr = ad;
      b_din  = d;
    end else begin
      a_addr = ad;
      a_din  = d;
    end
  endtask
  // Read result is due one edge after capture, one more with out reg
  task automatic expect_rd(input bit p, input logic [17:0] v);
    q.push_back('{cyc + 2 + int'(cfg_out_reg), p, v});
  endtask
  task automatic flush();
    @(negedge core_clk);
    {a_en, b_en} = 2'b00;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic preload(input bit z);
    int n;
    int reqs;
    n = 0;
    reqs = 0;
    @(negedge core_clk);
    {cfg_init_zero, cfg_init_start} = {z, 1'b1};
    @(negedge core_clk);
    cfg_init_start = 1'b0;
    check_flag(cfg_busy, 1'b1);
    while (cfg_busy === 1'b1 && n < 8000) begin
      @(negedge core_clk);
      reqs += int'(flash_rd_req);
      n++;
    end
    check_flag(cfg_busy, 1'b0);
    check_data(18'(reqs), z ? 18'h0 : 18'h200);
  endtask
  // Monitor takes the oldest note once its result is due
  always @(negedge core_clk) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      e = q.pop_front();
      check_data(e.p ? b_dout : a_dout, e.v);
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check_flag(fifo_empty, 1'b1);
    check_data(a_dout, DOUT_RST);
    // Flash image read back as 512 x 18 words on port B
    preload(1'b0);
    pushed.delete();
    for (int k = 0; k < 4; k++) begin
      top = (k == 2) ? 511 : (k == 3) ? 200 : k;
      port_op(1, 0, 13'(top), 18'h0);
      r = 18'(cfg_image_base + 16'(top));
      expect_rd(1, {r[1:0], r[15:0]});
    end
    flush();
    preload(1'b1);
    port_op(1, 0, 13'h3, 18'h0);
    expect_rd(1, 18'h0);
    flush();
    // Every single-port shape at both ends of its depth, both latencies
    cfg_mode = 2'h0;
    for (int o = 0; o < 2; o++) begin
      for (int w = 0; w < 4; w++) begin
        {cfg_out_reg, cfg_width_a} = {1'(o), 3'(w)};
        top = (w == 3) ? 1023 : (8192 >> w) - 1;
        m = (w == 3) ? 18'h1ff : 18'((1 << (1 << w)) - 1);
        r = 18'($random(seed)) & m;
        port_op(0, 1, 13'(top), r);
        port_op(0, 1, 13'h0, ~r & m);
        port_op(0, 0, 13'(top), 18'h0);
        expect_rd(0, r);
        port_op(0, 0, 13'h0, 18'h0);
        expect_rd(0, ~r & m);
        flush();
      end
    end
    // Deselected and locked writes leave stored data untouched
    {cfg_out_reg, cfg_width_a} = {1'b0, 3'h3};
    port_op(0, 1, 13'h7, 18'h0a5);
    @(negedge core_clk);
    {a_cs, a_din} = {1'b0, 18'h15a};
    port_op(0, 0, 13'h7, 18'h0);
    expect_rd(0, 18'h0a5);
    flush();
    cfg_wr_lock = 1'b1;
    port_op(0, 1, 13'h7, 18'h15a);
    port_op(0, 0, 13'h7, 18'h0);
    expect_rd(0, 18'h0a5);
    flush();
    cfg_wr_lock = 1'b0;
    // x9 word written on A seen bit by bit through a x1 port B
    {cfg_mode, cfg_width_b} = {2'h1, 3'h0};
    r = 18'($random(seed)) & 18'h1ff;
    port_op(0, 1, 13'h5, r);
    flush();
    for (int i = 0; i < 9; i++) begin
      port_op(1, 0, 13'(45 + i), 18'h0);
      expect_rd(1, 18'(r[i]));
    end
    // Bit 0 of that word flipped through port B, read back on A
    port_op(1, 1, 13'h2d, {17'h0, ~r[0]});
    port_op(0, 0, 13'h5, 18'h0);
    expect_rd(0, r ^ 18'h1);
    flush();
    // FIFO x18: fill past full, drain past empty
    {cfg_mode, cfg_width_a, cfg_width_b} = {2'h3, 3'h4, 3'h4};
    for (int i = 0; i < 513; i++) begin
      r = 18'($random(seed));
      port_op(0, 1, 13'h0, r);
      check_flag(fifo_full, i >= 512);
      if (i < 512) pushed.push_back(r);
    end
    for (int i = 0; i < 513; i++) begin
      port_op(1, 0, 13'h0, 18'h0);
      check_flag(fifo_empty, i >= 512);
      expect_rd(1, pushed[(i < 512) ? i : 511]);
    end
    flush();
    check_flag(fifo_empty, 1'b1);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
